// File: logic/bcp_defs.vh
// constants for the buffered compare pwm block
`ifndef BCP_DEFS_VH
`define BCP_DEFS_VH
`define BCP_CNT_W       16
`define BCP_MOD_RESET   16'hFFFF
`define BCP_CMP_RESET   16'h0000
// compare action field encoding (two bits)
`define BCP_ACT_NONE    2'h0
`define BCP_ACT_TOGGLE  2'h1
`define BCP_ACT_CLEAR   2'h2
`define BCP_ACT_SET     2'h3
`endif

// File: logic/bcp_channel.v
// one compare channel: match detection and pin action
`timescale 1ns/100ps
module bcp_channel #(
    parameter W = 16
) (
    input  wire         mclk,
    input  wire         rst,
    input  wire [W-1:0] count,
    input  wire         overflow,
    input  wire [W-1:0] compare_value,
    input  wire [1:0]   compare_action,
    input  wire         toggle_on_overflow,
    input  wire         enable,
    output reg          pin_level
);
`include "bcp_defs.vh"
    reg next_pin;
    wire match;
    assign match = enable && (count == compare_value);

    always @* begin
        next_pin = pin_level;
        // overflow toggle first, then compare action; a set or clear match on the wrap cycle wins, a toggle match undoes the overflow toggle
        if (enable && overflow && toggle_on_overflow) begin
            next_pin = ~pin_level;
        end
        if (match) begin
            case (compare_action)
                `BCP_ACT_TOGGLE: next_pin = ~next_pin;
                `BCP_ACT_CLEAR:  next_pin = 1'b0;
                `BCP_ACT_SET:    next_pin = 1'b1;
                default:         next_pin = next_pin;
            endcase
        end
    end

    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            pin_level <= 1'b0;
        end else begin
            pin_level <= next_pin;
        end
    end
endmodule

// File: logic/bcp_top.v
// buffered compare and pwm pair: counter, channel hand-over, pin muxing
`timescale 1ns/100ps
`include "bcp_defs.vh"
module bcp_top #(
    parameter W = `BCP_CNT_W
) (
    input  wire         mclk,
    input  wire         rst,
    input  wire         channel_link_select,
    input  wire [W-1:0] modulo_value,
    input  wire [W-1:0] ch0_compare_data,
    input  wire         ch0_compare_write,
    input  wire [W-1:0] ch1_compare_data,
    input  wire         ch1_compare_write,
    input  wire         ch0_enable,
    input  wire [1:0]   ch0_action,
    input  wire         ch0_toggle_ovf,
    input  wire         ch1_enable,
    input  wire [1:0]   ch1_action,
    input  wire         ch1_toggle_ovf,
    input  wire         gpio_b_out,
    input  wire         gpio_b_drive,
    output reg  [W-1:0] count,
    output reg          overflow_pulse,
    output reg          active_channel,
    output reg          compare_out_pin_a,
    output reg          compare_out_pin_b,
    output reg          pin_b_oe_n
);
    // ==========================================
    // compare registers and hand-over state
    reg  [W-1:0] ch0_compare;
    reg  [W-1:0] ch1_compare;
    reg          last_written;
    reg          link_prev;
    wire         wrap;
    wire [W-1:0] active_compare;
    wire         pin_a_level;
    wire         pin_b_level;
    wire         ch1_unlinked_en;

    assign wrap = (count == modulo_value);

    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            count          <= `BCP_CMP_RESET;
            overflow_pulse <= 1'b0;
        end else begin
            overflow_pulse <= wrap;
            if (wrap) begin
                count <= {W{1'b0}};
            end else begin
                count <= count + 1'b1;
            end
        end
    end

    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            ch0_compare <= `BCP_CMP_RESET;
            ch1_compare <= `BCP_CMP_RESET;
        end else begin
            // new values land at once; active one acts like plain compare
            if (ch0_compare_write) begin
                ch0_compare <= ch0_compare_data;
            end
            if (ch1_compare_write) begin
                ch1_compare <= ch1_compare_data;
            end
        end
    end

    // ==========================================
    // channel selection across overflows
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            last_written   <= 1'b0;
            active_channel <= 1'b0;
            link_prev      <= 1'b0;
        end else begin
            link_prev <= channel_link_select;
            if (channel_link_select && !link_prev) begin
                last_written   <= 1'b0;
                active_channel <= 1'b0;
            end else begin
                // both written in one cycle: channel 1 treated as last
                if (ch1_compare_write) begin
                    last_written <= 1'b1;
                end else if (ch0_compare_write) begin
                    last_written <= 1'b0;
                end
                // hand-over only on wrap, never mid-period
                if (channel_link_select && wrap) begin
                    active_channel <= ch1_compare_write ? 1'b1 :
                                      ch0_compare_write ? 1'b0 : last_written;
                end
            end
        end
    end

    assign active_compare = (channel_link_select && active_channel) ?
                            ch1_compare : ch0_compare;

    // linked: channel 0 controls alone, channel 1 controls are ignored
    assign ch1_unlinked_en = ch1_enable && !channel_link_select;

    bcp_channel #(.W(W)) u_ch_a (
        .mclk               (mclk),
        .rst                (rst),
        .count              (count),
        .overflow           (wrap),
        .compare_value      (active_compare),
        .compare_action     (ch0_action),
        .toggle_on_overflow (ch0_toggle_ovf),
        .enable             (ch0_enable),
        .pin_level          (pin_a_level)
    );

    bcp_channel #(.W(W)) u_ch_b (
        .mclk               (mclk),
        .rst                (rst),
        .count              (count),
        .overflow           (wrap),
        .compare_value      (ch1_compare),
        .compare_action     (ch1_action),
        .toggle_on_overflow (ch1_toggle_ovf),
        .enable             (ch1_unlinked_en),
        .pin_level          (pin_b_level)
    );

    // ==========================================
    // pin drivers
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            compare_out_pin_a <= 1'b0;
            compare_out_pin_b <= 1'b0;
            pin_b_oe_n        <= 1'b1;
        end else begin
            compare_out_pin_a <= pin_a_level;
            if (channel_link_select) begin
                compare_out_pin_b <= gpio_b_out;
                pin_b_oe_n        <= ~gpio_b_drive;
            end else begin
                compare_out_pin_b <= pin_b_level;
                pin_b_oe_n        <= ~ch1_enable;
            end
        end
    end
endmodule

// File: verification/bcp_load.sv
// far-side load model: measures pulse width and period on pin a
`timescale 1ns/100ps
module bcp_load (
    input  wire        mclk,
    input  wire        pin,
    output reg  [15:0] high_len,
    output reg  [15:0] period_len
);
    // ====
    // counts whole cycles, so widths read in mclk periods
    reg [15:0] hc;
    reg [15:0] pc;
    reg        last = 1'b0;
    always @(posedge mclk) begin
        last <= pin;
        hc <= pin ? hc + 16'h0001 : 16'h0000;
        pc <= (pin && !last) ? 16'h0001 : pc + 16'h0001;
        if (!pin && last)
            high_len <= hc;
        if (pin && !last)
            period_len <= pc;
    end
endmodule

// File: verification/bcp_assertions.sv
// port assertions for the buffered compare pwm pair
`timescale 1ns/100ps
module bcp_checker #(
    parameter W = 16
) (
    input wire         mclk,
    input wire         rst,
    input wire         channel_link_select,
    input wire [W-1:0] modulo_value,
    input wire         ch0_enable,
    input wire [1:0]   ch0_action,
    input wire         ch0_toggle_ovf,
    input wire         gpio_b_drive,
    input wire [W-1:0] count,
    input wire         overflow_pulse,
    input wire         active_channel,
    input wire         compare_out_pin_a,
    input wire         pin_b_oe_n
);
    // ====
    // modulo held steady by users
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    a_wrap_zero:
    assert property (count == modulo_value |=> !(|count) && overflow_pulse) else $error("no wrap");
    a_count_step:
    assert property (count != modulo_value |=> count == $past(count) + 1'b1) else $error("bad step");
    a_ovf_cause:
    assert property (overflow_pulse |-> $past(count == modulo_value)) else $error("stray ovf");
    a_ovf_single:
    assert property (overflow_pulse |=> !overflow_pulse) else $error("long ovf");
    a_link_first:
    assert property ($rose(channel_link_select) |=> !active_channel) else $error("not ch0");
    a_buffer_hold:
    assert property (channel_link_select && $past(channel_link_select, 2) && !overflow_pulse
        |-> $stable(active_channel)) else $error("mid-period swap");
    a_pin_b_free:
    assert property (channel_link_select && $past(channel_link_select)
        |-> pin_b_oe_n == !$past(gpio_b_drive)) else $error("pin b held");
    a_pwm_toggle:
    assert property (overflow_pulse && !channel_link_select && ch0_enable && ch0_toggle_ovf
        && ch0_action == 2'h0 |=> $changed(compare_out_pin_a)) else $error("no toggle");
endmodule
bind bcp_top bcp_checker #(.W(W)) i_chk (.*);

// File: verification/tb_top.sv
// self-checking bench for the buffered compare pwm pair
`timescale 1ns/100ps
`include "bcp_defs.vh"
module tb_top;
    reg        mclk = 1'b0, rst = 1'b1, channel_link_select = 1'b0;
    reg [15:0] modulo_value = 16'h0009, ch0_compare_data = 16'h0000, ch1_compare_data = 16'h0000;
    reg        ch0_compare_write = 1'b0, ch1_compare_write = 1'b0, ch0_enable = 1'b1;
    reg        ch0_toggle_ovf = 1'b1, ch1_enable = 1'b0, ch1_toggle_ovf = 1'b0;
    reg [1:0]  ch0_action = 2'h0, ch1_action = 2'h0;
    reg        gpio_b_out = 1'b1, gpio_b_drive = 1'b0;
    wire [15:0] count, high_len, period_len;
    wire       overflow_pulse, active_channel, compare_out_pin_a, compare_out_pin_b, pin_b_oe_n;
    integer    n_mismatch = 0, n_checks = 0;
    bcp_top i_dut (.*);
    bcp_load i_load (.mclk(mclk), .pin(compare_out_pin_a), .high_len(high_len),
                     .period_len(period_len));
    initial forever #12.5 mclk = ~mclk;
    // ====
    task chk(input [15:0] got, input [15:0] exp);
        begin
            n_checks = n_checks + 1;
            if (got !== exp) begin
                n_mismatch = n_mismatch + 1;
                $display("BAD %0t got %h exp %h", $time, got, exp);
            end
        end
    endtask
    task wr(input ch, input [15:0] v);
        begin
            ch0_compare_data = v;
            ch1_compare_data = v;
            ch0_compare_write = !ch;
            ch1_compare_write = ch;
            @(negedge mclk);
            ch0_compare_write = 1'b0;
            ch1_compare_write = 1'b0;
        end
    endtask
    // watchdog covers a missing overflow
    task ovf;
        begin
            @(posedge overflow_pulse);
            @(negedge mclk);
        end
    endtask
    task p(input [15:0] e);
        begin
            repeat (9) @(negedge mclk);
            chk(high_len, e);
        end
    endtask
    task finish_test;
        begin
            $display("checks %0d mismatches %0d", n_checks, n_mismatch);
            if (n_mismatch == 0 && n_checks > 0)
                $display("bench passed");
            else
                $display("bench failed");
            $finish;
        end
    endtask
    initial begin
        #20000;
        n_mismatch = n_mismatch + 1;
        finish_test;
    end
    // ====
    initial begin
        repeat (2) @(negedge mclk);
        rst = 1'b0;
        chk(count, 16'h0000);
        wr(0, 16'h0003);
        ovf;
        ovf;
        ch0_action = `BCP_ACT_CLEAR;
        repeat (3) ovf;
        p(16'h0004);
        chk(period_len, 16'h000a);
        $display("test unlinked done");
        channel_link_select = 1'b1;
        gpio_b_drive = 1'b1;
        gpio_b_out = 1'b0;
        ch1_enable = 1'b1;
        ch1_action = `BCP_ACT_SET;
        ovf;
        p(16'h0004);
        ovf;
        wr(1, 16'h0006);
        chk(active_channel, 1'b0);
        p(16'h0004);
        ovf;
        chk(active_channel, 1'b1);
        p(16'h0007);
        chk(pin_b_oe_n, 1'b0);
        chk(compare_out_pin_b, 16'h0000);
        ovf;
        wr(0, 16'h0002);
        p(16'h0007);
        ovf;
        chk(active_channel, 1'b0);
        p(16'h0003);
        ovf;
        wr(0, 16'h0005);
        p(16'h0006);
        $display("test linked done");
        finish_test;
    end
endmodule
